//--- src/hcrr_pkg.sv
`default_nettype none
package hcrr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int SLOT_W = 3;
    localparam int N_SLOTS = 8;

    // Readout window: four channels, negative then positive spin, high byte first
    localparam logic [7:0] CHAN3_NEG_SPIN_HIGH = 8'h1a;
    localparam logic [7:0] CHAN3_NEG_SPIN_LOW = 8'h1b;
    localparam logic [7:0] CHAN3_POS_SPIN_HIGH = 8'h1c;
    localparam logic [7:0] CHAN3_POS_SPIN_LOW = 8'h1d;
    localparam logic [7:0] CHAN2_NEG_SPIN_HIGH = 8'h1e;
    localparam logic [7:0] CHAN2_NEG_SPIN_LOW = 8'h1f;
    localparam logic [7:0] CHAN2_POS_SPIN_HIGH = 8'h20;
    localparam logic [7:0] CHAN2_POS_SPIN_LOW = 8'h21;
    localparam logic [7:0] CHAN1_NEG_SPIN_HIGH = 8'h22;
    localparam logic [7:0] CHAN1_NEG_SPIN_LOW = 8'h23;
    localparam logic [7:0] CHAN1_POS_SPIN_HIGH = 8'h24;
    localparam logic [7:0] CHAN1_POS_SPIN_LOW = 8'h25;
    localparam logic [7:0] CHAN5_NEG_SPIN_HIGH = 8'h26;
    localparam logic [7:0] CHAN5_NEG_SPIN_LOW = 8'h27;
    localparam logic [7:0] CHAN5_POS_SPIN_HIGH = 8'h28;
    localparam logic [7:0] CHAN5_POS_SPIN_LOW = 8'h29;
    localparam logic [7:0] READOUT_FIRST = CHAN3_NEG_SPIN_HIGH;
    localparam logic [7:0] READOUT_LAST = CHAN5_POS_SPIN_LOW;

    localparam logic [7:0] MIDDLE_ELEMENT_CONTROL = 8'h2b;
    localparam logic [7:0] OUTER_ATTENUATION = 8'h2c;
    localparam logic [7:0] COORDINATE_SCALING = 8'h2d;
    localparam logic [7:0] SECOND_CONTROL = 8'h2e;

    localparam logic [7:0] READOUT_RESET = 8'h00;
    localparam logic [11:0] SAMPLE_RESET = 12'h000;
    localparam logic [7:0] MIDDLE_RESET = 8'h00;
    localparam logic [7:0] ATTEN_RESET = 8'h06;
    localparam logic [7:0] SCALING_RESET = 8'h09;
    localparam logic [7:0] SCALING_MODULE_VALUE = 8'h16;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Second control: bits 7 and 2 fixed one, 6..3 and 0 fixed zero, bit 1 inverts
    localparam logic [7:0] SECOND_FIXED_MASK = 8'hfd;
    localparam logic [7:0] SECOND_FIXED_VALUE = 8'h84;
    localparam int SPIN_INVERT_BIT = 1;
    localparam logic SPIN_INVERT_RESET = 1'b0;

    // Sign and high nibble positions of a 12-bit readout
    localparam int SAMPLE_SIGN_BIT = 11;
    localparam int HIGH_NIBBLE_LSB = 8;
    localparam logic [11:0] SAMPLE_MOST_NEG = 12'h800;
    localparam logic [11:0] SAMPLE_MOST_POS = 12'h7ff;

    localparam logic [2:0] CHANNEL_1 = 3'h1;
    localparam logic [2:0] CHANNEL_2 = 3'h2;
    localparam logic [2:0] CHANNEL_3 = 3'h3;
    localparam logic [2:0] CHANNEL_5 = 3'h5;
endpackage
`default_nettype wire

//--- src/hcrr_regs.sv
`default_nettype none
module hcrr_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [hcrr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [hcrr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [hcrr_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic meas_valid,
    input wire logic [2:0] meas_channel,
    input wire logic meas_positive,
    input wire logic [hcrr_pkg::SAMPLE_W-1:0] meas_value,
    output logic [hcrr_pkg::DATA_W-1:0] middle_ctrl,
    output logic [hcrr_pkg::DATA_W-1:0] outer_atten,
    output logic [hcrr_pkg::DATA_W-1:0] coord_scale,
    output logic spin_invert,
    output logic test_bits_mismatch,
    output logic scaling_not_module_value
);
    import hcrr_pkg::*;

    // Maps a register address inside the readout window to its slot and half
    function automatic logic [SLOT_W-1:0] addr_slot(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] rel;
        rel = addr - READOUT_FIRST;
        return rel[SLOT_W:1];
    endfunction

    function automatic logic addr_is_high(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] rel;
        rel = addr - READOUT_FIRST;
        return ~rel[0];
    endfunction

    function automatic logic addr_in_readout(input logic [ADDR_W-1:0] addr);
        return (addr >= READOUT_FIRST) && (addr <= READOUT_LAST);
    endfunction

    // Slot order follows the address order: ch3, ch2, ch1, ch5, negative spin first
    function automatic logic [SLOT_W:0] channel_slot(input logic [2:0] chan,
                                                      input logic positive);
        logic [1:0] pair;
        logic ok;
        pair = 2'h0;
        ok = 1'b1;
        unique case (chan)
            CHANNEL_3: pair = 2'h0;
            CHANNEL_2: pair = 2'h1;
            CHANNEL_1: pair = 2'h2;
            CHANNEL_5: pair = 2'h3;
            default: ok = 1'b0;
        endcase
        return {ok, pair, positive};
    endfunction

    // Negating -2048 would wrap to itself, so it saturates instead
    function automatic logic [SAMPLE_W-1:0] negate_sample(input logic [SAMPLE_W-1:0] v);
        logic [SAMPLE_W-1:0] neg;
        neg = SAMPLE_W'(~v + 12'h001);
        if (v == SAMPLE_MOST_NEG) begin
            neg = SAMPLE_MOST_POS;
        end
        return neg;
    endfunction

    function automatic logic [DATA_W-1:0] high_byte(input logic [SAMPLE_W-1:0] v);
        return {{4{v[SAMPLE_SIGN_BIT]}}, v[SAMPLE_SIGN_BIT:HIGH_NIBBLE_LSB]};
    endfunction

    function automatic logic [DATA_W-1:0] low_byte(input logic [SAMPLE_W-1:0] v);
        return v[HIGH_NIBBLE_LSB-1:0];
    endfunction

    hcrr_store_if store_bus ();

    hcrr_sample_store u_store (
        .clk(clk),
        .port(store_bus.store)
    );

    // Register bank
    logic [DATA_W-1:0] middle_reg;
    logic [DATA_W-1:0] atten_reg;
    logic [DATA_W-1:0] scaling_reg;
    logic invert_reg;
    logic mismatch_reg;

    wire logic bank_clear = ~rst_n | soft_reset;

    // Write decode
    wire logic wr_middle = reg_wr_en && (reg_addr == MIDDLE_ELEMENT_CONTROL);
    wire logic wr_atten = reg_wr_en && (reg_addr == OUTER_ATTENUATION);
    wire logic wr_scaling = reg_wr_en && (reg_addr == COORDINATE_SCALING);
    wire logic wr_second = reg_wr_en && (reg_addr == SECOND_CONTROL);
    wire logic wdata_fixed_ok = (reg_wdata & SECOND_FIXED_MASK) == SECOND_FIXED_VALUE;

    // Capture path from the measurement front end
    wire logic [SLOT_W:0] meas_map = channel_slot(meas_channel, meas_positive);
    wire logic meas_take = meas_valid && meas_map[SLOT_W];
    wire logic [SAMPLE_W-1:0] meas_stored =
        invert_reg ? negate_sample(meas_value) : meas_value;

    assign store_bus.clear = bank_clear;
    assign store_bus.wr_en = meas_take;
    assign store_bus.wr_slot = meas_map[SLOT_W-1:0];
    assign store_bus.wr_data = meas_stored;
    assign store_bus.rd_slot = addr_slot(reg_addr);

    // Read decode
    wire logic rd_readout = addr_in_readout(reg_addr);
    wire logic [DATA_W-1:0] readout_byte = addr_is_high(reg_addr)
        ? high_byte(store_bus.rd_data) : low_byte(store_bus.rd_data);
    wire logic [DATA_W-1:0] second_view =
        SECOND_FIXED_VALUE | (DATA_W'(invert_reg) << SPIN_INVERT_BIT);
    wire logic [DATA_W-1:0] next_rdata =
        rd_readout ? readout_byte :
        (reg_addr == MIDDLE_ELEMENT_CONTROL) ? middle_reg :
        (reg_addr == OUTER_ATTENUATION) ? atten_reg :
        (reg_addr == COORDINATE_SCALING) ? scaling_reg :
        (reg_addr == SECOND_CONTROL) ? second_view : UNMAPPED_READ;

    always_ff @(posedge clk) begin
        if (bank_clear) begin
            middle_reg <= MIDDLE_RESET;
        end else if (wr_middle) begin
            middle_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (bank_clear) begin
            atten_reg <= ATTEN_RESET;
        end else if (wr_atten) begin
            atten_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (bank_clear) begin
            scaling_reg <= SCALING_RESET;
        end else if (wr_scaling) begin
            scaling_reg <= reg_wdata;
        end
    end

    // The invert bit and a test-bit mismatch flag are stored; the test bits read back their fixed pattern
    always_ff @(posedge clk) begin
        if (bank_clear) begin
            invert_reg <= SPIN_INVERT_RESET;
            mismatch_reg <= 1'b0;
        end else if (wr_second) begin
            invert_reg <= reg_wdata[SPIN_INVERT_BIT];
            mismatch_reg <= ~wdata_fixed_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= UNMAPPED_READ;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd_en ? next_rdata : reg_rdata;
            reg_rd_valid <= reg_rd_en;
        end
    end

    // Mirrors to the algorithm, all straight from flip-flops
    always_ff @(posedge clk) begin
        if (bank_clear) begin
            middle_ctrl <= MIDDLE_RESET;
            outer_atten <= ATTEN_RESET;
            coord_scale <= SCALING_RESET;
            spin_invert <= SPIN_INVERT_RESET;
            test_bits_mismatch <= 1'b0;
            scaling_not_module_value <= 1'b1;
        end else begin
            middle_ctrl <= middle_reg;
            outer_atten <= atten_reg;
            coord_scale <= scaling_reg;
            spin_invert <= invert_reg;
            test_bits_mismatch <= mismatch_reg;
            scaling_not_module_value <= scaling_reg != SCALING_MODULE_VALUE;
        end
    end
endmodule
`default_nettype wire

//--- src/hcrr_sample_store.sv
`default_nettype none
module hcrr_sample_store (
    input wire logic clk,
    hcrr_store_if.store port
);
    import hcrr_pkg::*;

    logic [SAMPLE_W-1:0] sample [N_SLOTS];

    // Clear covers both pin reset and soft reset, and beats a same-cycle write
    always_ff @(posedge clk) begin
        if (port.clear) begin
            for (int i = 0; i < N_SLOTS; i++) begin
                sample[i] <= SAMPLE_RESET;
            end
        end else if (port.wr_en) begin
            sample[port.wr_slot] <= port.wr_data;
        end
    end

    assign port.rd_data = sample[port.rd_slot];
endmodule
`default_nettype wire

//--- src/hcrr_store_if.sv
`default_nettype none
interface hcrr_store_if;
    import hcrr_pkg::*;
    logic clear;
    logic wr_en;
    logic [SLOT_W-1:0] wr_slot;
    logic [SAMPLE_W-1:0] wr_data;
    logic [SLOT_W-1:0] rd_slot;
    logic [SAMPLE_W-1:0] rd_data;

    modport ctrl (output clear, output wr_en, output wr_slot, output wr_data,
                  output rd_slot, input rd_data);
    modport store (input clear, input wr_en, input wr_slot, input wr_data,
                   input rd_slot, output rd_data);
endinterface
`default_nettype wire

//--- testbench/hcrr_host.sv
`default_nettype none
module hcrr_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import hcrr_pkg::*;
    initial {reg_addr, reg_wr_en, reg_wdata, reg_rd_en} = '0;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        // Stale data would hide a missing strobe check
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end
        end
    endtask
    task setup();
        wr(MIDDLE_ELEMENT_CONTROL, 8'h00);
        wr(OUTER_ATTENUATION, 8'h06);
        wr(COORDINATE_SCALING, SCALING_MODULE_VALUE);
        wr(SECOND_CONTROL, SECOND_FIXED_VALUE);
    endtask
endmodule
`default_nettype wire

//--- testbench/hcrr_regs_props.sv
`default_nettype none
module hcrr_regs_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic [7:0] outer_atten,
    input wire logic [7:0] coord_scale,
    input wire logic scaling_not_module_value
);
    timeunit 1ns;
    timeprecision 1ps;
    import hcrr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire rd_even = reg_rd_en && !reg_addr[0] && reg_addr >= READOUT_FIRST
        && reg_addr <= READOUT_LAST;
    a_rd_valid: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read gave no valid");
    a_no_spur_valid: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("valid without read");
    a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
    a_high_sign: assert property (rd_even |=> reg_rdata[7:4] == {4{reg_rdata[3]}})
        else $error("high byte not sign extended");
    a_unmapped_zero: assert property (reg_rd_en && reg_addr == 8'h2a
        |=> reg_rdata == 8'h00) else $error("gap address not zero");
    a_fixed_bits: assert property (reg_rd_en && reg_addr == SECOND_CONTROL
        |=> (reg_rdata & SECOND_FIXED_MASK) == SECOND_FIXED_VALUE) else $error("test bits wrong");
    a_scale_write: assert property (reg_wr_en && reg_addr == COORDINATE_SCALING
        && !soft_reset ##1 !reg_wr_en && !soft_reset
        |=> coord_scale == $past(reg_wdata, 2))
        else $error("scaling write lost");
    a_scale_flag: assert property (scaling_not_module_value
        == (coord_scale != SCALING_MODULE_VALUE)) else $error("scaling flag wrong");
    a_soft_clear: assert property (soft_reset ##1 !reg_wr_en |=>
        outer_atten == ATTEN_RESET && coord_scale == SCALING_RESET)
        else $error("soft reset missed");
    c_read_even: cover property (rd_even);
    c_scale_write: cover property (reg_wr_en && reg_addr == COORDINATE_SCALING);
    c_soft: cover property (soft_reset);
endmodule
bind hcrr_regs hcrr_regs_props u_hcrr_regs_props (.clk(clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .outer_atten(outer_atten), .coord_scale(coord_scale),
    .scaling_not_module_value(scaling_not_module_value));
`default_nettype wire

//--- testbench/hcrr_regs_tb.sv
`default_nettype none
module hcrr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hcrr_pkg::*;
    logic clk = 0, rst_n = 0, soft_reset = 0, meas_valid = 0, meas_positive = 0;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, spin_invert, test_bits_mismatch, snmv, inv, bad;
    logic [2:0] meas_channel = 0;
    logic [11:0] meas_value = 0;
    logic [11:0] samp [8];
    logic [7:0] reg_addr, reg_wdata, reg_rdata, middle_ctrl, outer_atten, coord_scale, m, j, t;
    logic [31:0] rs = 32'd98098;
    int failures = 0, compares = 0;
    always #2 clk = ~clk;
    hcrr_host u_hcrr_host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid));
    hcrr_regs u_hcrr_regs (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .meas_valid(meas_valid), .meas_channel(meas_channel), .meas_positive(meas_positive),
        .meas_value(meas_value), .middle_ctrl(middle_ctrl), .outer_atten(outer_atten),
        .coord_scale(coord_scale), .spin_invert(spin_invert),
        .test_bits_mismatch(test_bits_mismatch), .scaling_not_module_value(snmv));
    function logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [7:0] exp_rd(logic [7:0] a);
        logic [11:0] s;
        s = samp[3'((a - 8'h1a) >> 1)];
        if (a >= READOUT_FIRST && a <= READOUT_LAST) return a[0] ? s[7:0] : {{4{s[11]}}, s[11:8]};
        case (a)
            MIDDLE_ELEMENT_CONTROL: return m;
            OUTER_ATTENUATION: return j;
            COORDINATE_SCALING: return t;
            SECOND_CONTROL: return SECOND_FIXED_VALUE | {6'h00, inv, 1'b0};
            default: return 8'h00;
        endcase
    endfunction
    task reset_model();
        foreach (samp[i]) samp[i] = 12'h000;
        {m, j, t, inv} = {8'h00, 8'h06, 8'h09, 1'b0};
        bad = 1'b0;
    endtask
    task give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: read %h, want %h", $time, seen, exp);
        end
    endtask
    // Mirrors lag their registers by one cycle; called only after a full readback
    task chk_mirrors();
        chk(middle_ctrl, m);
        chk(outer_atten, j);
        chk(coord_scale, t);
        chk({7'h00, spin_invert}, {7'h00, inv});
        chk({7'h00, test_bits_mismatch}, {7'h00, bad});
        chk({7'h00, snmv}, {7'h00, t != SCALING_MODULE_VALUE});
    endtask
    task read_all();
        logic [7:0] d;
        logic ok;
        for (int a = 8'h19; a <= 8'h2f; a++) begin
            u_hcrr_host.rd(8'(a), d, ok);
            if (!ok) begin
                failures++;
                $display("unexpected at %0t: no read answer", $time);
                give_verdict();
            end
            chk(d, exp_rd(8'(a)));
        end
        chk_mirrors();
    endtask
    task capture(logic [2:0] c, logic p, logic [11:0] v);
        int b;
        @(posedge clk);
        {meas_valid, meas_channel, meas_positive, meas_value} <= {1'b1, c, p, v};
        @(posedge clk);
        meas_valid <= 1'b0;
        b = (c == 3) ? 0 : (c == 2) ? 2 : (c == 1) ? 4 : 6;
        if (c inside {1, 2, 3, 5})
            samp[b + p] = !inv ? v : (v == SAMPLE_MOST_NEG) ? SAMPLE_MOST_POS : -v;
    endtask
    initial begin
        logic [31:0] r;
        reset_model();
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        read_all();
        for (int a = 8'h19; a <= 8'h2f; a++) begin
            r = xs();
            u_hcrr_host.wr(8'(a), r[7:0]);
            case (a)
                8'h2b: m = r[7:0];
                8'h2c: j = r[7:0];
                8'h2d: t = r[7:0];
                8'h2e: begin
                    inv = r[1];
                    bad = (r[7:0] & SECOND_FIXED_MASK) != SECOND_FIXED_VALUE;
                end
            endcase
        end
        read_all();
        for (int k = 0; k < 2; k++) begin
            u_hcrr_host.setup();
            {m, j, t, inv} = {8'h00, 8'h06, 8'h16, 1'(k)};
            bad = 1'b0;
            if (k == 1) u_hcrr_host.wr(SECOND_CONTROL, 8'h86);
            for (int i = 0; i < 12; i++) begin
                r = xs();
                capture(r[2:0], r[3], i < 2 ? (i ? SAMPLE_MOST_POS : SAMPLE_MOST_NEG) : r[31:20]);
            end
            read_all();
        end
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        reset_model();
        read_all();
        u_hcrr_host.wr(COORDINATE_SCALING, 8'h16);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reset_model();
        read_all();
        give_verdict();
    end
endmodule
`default_nettype wire
